// ---- rtl/add_group_defs.svh ----
`ifndef ADD_GROUP_DEFS_SVH
`define ADD_GROUP_DEFS_SVH

// opcode bytes and patterns
`define OPC_ADD_IMM 8'h03
`define OPC_ADD_WITH_CARRY_OP_IMM 8'h13
`define OPC_ADD_REG 5'h0D
`define OPC_ADD_WITH_CARRY_OP_REG 5'h0F
`define OPC_ADD_IND 7'h30
`define OPC_ADD_WITH_CARRY_OP_IND 7'h38

// field positions
`define REG_FIELD_MSB 2
`define IND_SEL_BIT 0
`define PAGE_FIELD_MSB 7
`define PAGE_FIELD_LSB 5
`define HALF_BIT 4
`define CARRY_BIT 8

// port codes: 1, 2, expanders 4 to 7
`define PORT_ONE 3'h1
`define PORT_TWO 3'h2
`define PORT_EXP_LO 3'h4

// reset values
`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0

// machine cycle divider default, in sys_clk cycles
`define MC_DIV_DEFAULT 4

`endif

// ---- rtl/add_group_pkg.sv ----
`default_nettype none

package add_group_pkg;

    typedef enum logic [0:0] {
        ST_FETCH = 1'b0,
        ST_IMM = 1'b1
    } exec_state_t;

    typedef struct packed {
        logic [7:0] sum;
        logic carry;
        logic half_carry;
    } alu_result_t;

    typedef logic [7:0] addr8_t;
    typedef logic [10:0] addr11_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] port_sel;
        logic port_ok;
        logic [2:0] page;
    } other_op_t;

endpackage : add_group_pkg

`default_nettype wire

// ---- rtl/accumulator_add_decode.sv ----
`include "add_group_defs.svh"
`default_nettype none

module accumulator_add_decode
    import add_group_pkg::*;
#(
    parameter int MC_DIV = `MC_DIV_DEFAULT,
    parameter int DMEM_DEPTH = 64,
    parameter int DMEM_AW = 6
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic prog_valid,
    input wire logic [7:0] prog_byte,
    output logic prog_ready,
    input wire logic mem_wr_en,
    input wire logic [DMEM_AW-1:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic instr_done,
    output logic other_valid,
    output other_op_t other_op
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic alu_result_t add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        alu_result_t r;
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.sum = full[7:0];
        r.carry = full[`CARRY_BIT];
        r.half_carry = low[`HALF_BIT];
        return r;
    endfunction : add8

    function automatic logic port_code_ok(input logic [2:0] p);
        return (p == `PORT_ONE) || (p == `PORT_TWO) || (p >= `PORT_EXP_LO);
    endfunction : port_code_ok

    ////////////////////////////////////////////////////////////////////////////////
    // machine cycle enable

    localparam int DIV_W = $clog2(MC_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MC_DIV - 1);

    logic [DIV_W-1:0] div_reg;
    logic mc_tick;

    assign mc_tick = (div_reg == DIV_LAST);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            div_reg <= '0;
        else if (mc_tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + DIV_W'(1);
    end

    // one program byte per machine cycle, so byte count equals cycle count
    assign prog_ready = mc_tick;

    logic take;
    assign take = mc_tick && prog_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // internal data memory, working registers at 0-7

    logic [7:0] dmem [DMEM_DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (mem_wr_en)
            dmem[mem_wr_addr] <= mem_wr_data;
    end

    logic [7:0] reg_val;
    logic [DMEM_AW-1:0] ind_addr;
    logic [7:0] ind_val;

    assign reg_val = dmem[DMEM_AW'(prog_byte[`REG_FIELD_MSB:0])];
    // only bits 0-5 of the pointer register reach the memory
    assign ind_addr = dmem[DMEM_AW'(prog_byte[`IND_SEL_BIT])][DMEM_AW-1:0];
    assign ind_val = dmem[ind_addr];

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    exec_state_t state_reg;
    logic imm_carry_reg;

    logic is_imm;
    logic is_reg;
    logic is_ind;
    logic use_carry;

    always_comb
    begin
        is_imm = (prog_byte == `OPC_ADD_IMM) || (prog_byte == `OPC_ADD_WITH_CARRY_OP_IMM);
        is_reg = (prog_byte[7:3] == `OPC_ADD_REG) || (prog_byte[7:3] == `OPC_ADD_WITH_CARRY_OP_REG);
        is_ind = (prog_byte[7:1] == `OPC_ADD_IND) || (prog_byte[7:1] == `OPC_ADD_WITH_CARRY_OP_IND);
        use_carry = (prog_byte == `OPC_ADD_WITH_CARRY_OP_IMM) || (prog_byte[7:3] == `OPC_ADD_WITH_CARRY_OP_REG) ||
                    (prog_byte[7:1] == `OPC_ADD_WITH_CARRY_OP_IND);
    end

    logic exec_en;
    logic [7:0] exec_b;
    logic exec_cin;
    alu_result_t res;

    always_comb
    begin
        exec_en = 1'b0;
        exec_b = 8'h00;
        exec_cin = 1'b0;
        case (state_reg)
            ST_FETCH:
            begin
                exec_en = take && (is_reg || is_ind);
                exec_b = is_ind ? ind_val : reg_val;
                exec_cin = use_carry && carry_flag;
            end
            ST_IMM:
            begin
                exec_en = take;
                exec_b = prog_byte;
                exec_cin = imm_carry_reg && carry_flag;
            end
            default:
            begin
                exec_en = 1'b0;
            end
        endcase
        res = add8(acc, exec_b, exec_cin);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_FETCH;
            imm_carry_reg <= `FLAG_RESET;
        end
        else if (take)
        begin
            case (state_reg)
                ST_FETCH:
                begin
                    if (is_imm)
                    begin
                        state_reg <= ST_IMM;
                        imm_carry_reg <= use_carry;
                    end
                end
                ST_IMM:
                    state_reg <= ST_FETCH;
                default:
                    state_reg <= ST_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // accumulator and flags

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            acc <= `ACC_RESET;
            carry_flag <= `FLAG_RESET;
            half_carry_flag <= `FLAG_RESET;
        end
        else if (exec_en)
        begin
            acc <= res.sum;
            carry_flag <= res.carry;
            half_carry_flag <= res.half_carry;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            instr_done <= 1'b0;
        else
            instr_done <= exec_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // opcodes outside the add group are handed on with their operand fields

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            other_valid <= 1'b0;
            other_op <= '0;
        end
        else
        begin
            other_valid <= take && (state_reg == ST_FETCH) && !is_imm && !is_reg && !is_ind;
            if (take && (state_reg == ST_FETCH))
            begin
                other_op.opcode <= prog_byte;
                other_op.port_sel <= prog_byte[`REG_FIELD_MSB:0];
                other_op.port_ok <= port_code_ok(prog_byte[`REG_FIELD_MSB:0]);
                // a10..a8 of an 11-bit address ride in the opcode's top bits
                other_op.page <= prog_byte[`PAGE_FIELD_MSB:`PAGE_FIELD_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_imm_enters_operand: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_FETCH && prog_byte == `OPC_ADD_IMM)
        |=> (state_reg == ST_IMM && !imm_carry_reg && !instr_done))
        else $error("add immediate did not wait for its operand");

    a_imm_sum_exact: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_IMM && !imm_carry_reg)
        |=> (acc == 8'($past(acc) + $past(prog_byte)) && state_reg == ST_FETCH))
        else $error("add immediate gave a wrong sum");

    a_reg_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_FETCH && prog_byte[7:3] == `OPC_ADD_REG)
        |=> (instr_done && state_reg == ST_FETCH && acc == 8'($past(acc) + $past(reg_val))))
        else $error("register add wrong or slow");

    a_ind_sum_exact: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_FETCH && prog_byte[7:1] == `OPC_ADD_IND)
        |=> (acc == 8'($past(acc) + $past(ind_val)) && instr_done))
        else $error("indirect add gave a wrong sum");

    a_add_with_carry_op_imm_carry: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_IMM && imm_carry_reg)
        |=> (acc == 8'($past(acc) + $past(prog_byte) + {7'h00, $past(carry_flag)})))
        else $error("add immediate with carry ignored the carry");

    a_flags_follow_sum: assert property (@(posedge sys_clk) disable iff (reset)
        exec_en |=> (half_carry_flag == (({1'b0, $past(acc[3:0])} +
            {1'b0, $past(exec_b[3:0])} + {4'h0, $past(exec_cin)}) > 5'h0F)))
        else $error("flags not updated by an add");

    a_flags_hold_idle: assert property (@(posedge sys_clk) disable iff (reset)
        !exec_en |=> ($stable(carry_flag) && $stable(half_carry_flag) && $stable(acc)))
        else $error("flags or accumulator moved without an add");

    a_port_code_legal: assert property (@(posedge sys_clk) disable iff (reset)
        other_valid |-> (other_op.port_ok == ((other_op.port_sel == 3'h1) ||
            (other_op.port_sel == 3'h2) || (other_op.port_sel[2] == 1'b1))))
        else $error("port code legality wrong");

    a_add_with_carry_op_reg_carry: assert property (@(posedge sys_clk) disable iff (reset)
        (take && state_reg == ST_FETCH && prog_byte[7:3] == `OPC_ADD_WITH_CARRY_OP_REG)
        |=> (instr_done && acc == 8'($past(acc) + $past(reg_val) + {7'h00, $past(carry_flag)})))
        else $error("register add with carry wrong");

    a_carry_bit7: assert property (@(posedge sys_clk) disable iff (reset)
        exec_en |=> (carry_flag == (({1'b0, $past(acc)} + {1'b0, $past(exec_b)} +
            {8'h00, $past(exec_cin)}) > 9'h0FF)))
        else $error("carry not taken from bit 7");

endmodule : accumulator_add_decode

`default_nettype wire

// ---- verif/accumulator_add_decode_tb.sv ----
`default_nettype none

module accumulator_add_decode_tb
    import add_group_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int MC = 4;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic prog_valid = 1'b0;
    logic [7:0] prog_byte = 8'h00;
    logic mem_wr_en = 1'b0;
    logic [5:0] mem_wr_addr = 6'h00;
    logic [7:0] mem_wr_data = 8'h00;
    logic prog_ready;
    logic [7:0] acc;
    logic carry_flag;
    logic half_carry_flag;
    logic instr_done;
    logic other_valid;
    other_op_t other_op;

    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] acc_m = 8'h00;
    logic c_m = 1'b0;

    accumulator_add_decode #(.MC_DIV(MC), .DMEM_DEPTH(64), .DMEM_AW(6)) uut (
        .sys_clk(sys_clk),
        .reset(reset),
        .prog_valid(prog_valid),
        .prog_byte(prog_byte),
        .prog_ready(prog_ready),
        .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data),
        .acc(acc),
        .carry_flag(carry_flag),
        .half_carry_flag(half_carry_flag),
        .instr_done(instr_done),
        .other_valid(other_valid),
        .other_op(other_op)
    );

    always #2.5 sys_clk = ~sys_clk;

    // a hung handshake would otherwise run forever
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task test_done;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task wmem(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        mem_wr_en = 1'b1;
        mem_wr_addr = a;
        mem_wr_data = d;
        @(negedge sys_clk);
        mem_wr_en = 1'b0;
    endtask : wmem

    // returns half a cycle after the taking edge, where one-cycle pulses stand
    task send(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge sys_clk);
        prog_valid = 1'b1;
        prog_byte = b;
        while (prog_ready !== 1'b1 && n < 16)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 16)
            n_fail++;
        @(negedge sys_clk);
        prog_valid = 1'b0;
        prog_byte = ~b;
    endtask : send

    task add_op(input logic [7:0] opc, input logic [7:0] opnd, input logic use_c,
                input logic two);
        logic [8:0] s;
        logic h;
        s = {1'b0, acc_m} + {1'b0, opnd} + {8'h00, use_c & c_m};
        h = ({1'b0, acc_m[3:0]} + {1'b0, opnd[3:0]} + {4'h0, use_c & c_m}) > 5'h0F;
        send(opc);
        if (two)
        begin
            // with carry: let one idle machine cycle pass, the operand must still be awaited
            if (use_c)
                repeat (MC) @(negedge sys_clk);
            chk(instr_done, 16'h0000);
            chk(acc, acc_m);
            send(opnd);
        end
        acc_m = s[7:0];
        c_m = s[8];
        chk({other_valid, instr_done}, 16'h0001);
        chk(acc, acc_m);
        chk({carry_flag, half_carry_flag}, {c_m, h});
        @(negedge sys_clk);
        chk(instr_done, 16'h0000);
    endtask : add_op

    ////////////////////////////////////////////////////////////////////////////////
    task t_imm;
        add_op(8'h03, 8'h0F, 1'b0, 1'b1);
        add_op(8'h03, 8'h01, 1'b0, 1'b1);
        add_op(8'h03, 8'hF0, 1'b0, 1'b1);
        add_op(8'h13, 8'h0E, 1'b1, 1'b1);
        add_op(8'h13, 8'hF1, 1'b1, 1'b1);
        add_op(8'h13, 8'h7F, 1'b1, 1'b1);
    endtask : t_imm

    task t_reg;
        logic [7:0] v;
        for (int r = 0; r < 8; r++)
            wmem(6'(r), 8'(r * 37 + 9));
        for (int r = 0; r < 8; r++)
        begin
            v = 8'(r * 37 + 9);
            add_op(8'h68 | 8'(r), v, 1'b0, 1'b0);
        end
        for (int r = 0; r < 8; r++)
        begin
            v = 8'(r * 37 + 9);
            add_op(8'h78 | 8'(r), v, 1'b1, 1'b0);
        end
    endtask : t_reg

    // upper pointer bits set so a full-width address would miss
    task t_ind;
        wmem(6'h00, 8'hE5);
        wmem(6'h01, 8'hC9);
        wmem(6'h25, 8'h9A);
        wmem(6'h09, 8'h6C);
        add_op(8'h60, 8'h9A, 1'b0, 1'b0);
        add_op(8'h61, 8'h6C, 1'b0, 1'b0);
        add_op(8'h70, 8'h9A, 1'b1, 1'b0);
        add_op(8'h71, 8'h6C, 1'b1, 1'b0);
    endtask : t_ind

    task t_other;
        logic [7:0] opc;
        logic [2:0] p;
        logic ok;
        for (int i = 0; i < 8; i++)
        begin
            p = ~3'(i);
            opc = {3'(i), 2'b10, p};
            ok = (p == 3'h1) || (p == 3'h2) || (p >= 3'h4);
            send(opc);
            chk(other_valid, 16'h0001);
            chk(other_op, {1'b0, opc, p, ok, 3'(i)});
            chk({instr_done, acc}, {1'b0, acc_m});
        end
    endtask : t_other

    // reset while an immediate waits for its operand: the next byte is an opcode again
    task t_reset;
        send(8'h03);
        @(negedge sys_clk);
        reset = 1'b1;
        @(negedge sys_clk);
        reset = 1'b0;
        acc_m = 8'h00;
        c_m = 1'b0;
        chk({acc, carry_flag, half_carry_flag, instr_done, other_valid}, 16'h0000);
        chk(other_op, 16'h0000);
        add_op(8'h68, 8'hE5, 1'b0, 1'b0);
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        chk({acc, carry_flag, half_carry_flag}, 16'h0000);
        for (int k = 0; k < MC; k++)
        begin
            chk(prog_ready, (k == MC - 1) ? 16'h0001 : 16'h0000);
            @(negedge sys_clk);
        end
        t_imm();
        t_reg();
        t_ind();
        t_other();
        t_reset();
        test_done();
    end

endmodule : accumulator_add_decode_tb

`default_nettype wire
